/* host_sideband_outputs_busy_bench.sv */
// Testbench: sideband pins, busy flag and interrupt
`timescale 1ns/1ps
module host_sideband_outputs_busy_bench;
  logic                clk_i;
  logic                rst_b_i;
  logic [1:0]          addr_i;
  logic [7:0]          wdata_i;
  logic                wr_i;
  logic                rd_i;
  logic [7:0]          rdata_o;
  hsb_pkg::hsb_cycle_t cycle_i;
  hsb_pkg::hsb_pin_t   wk_o;
  hsb_pkg::hsb_pin_t   smi_o;
  hsb_pkg::hsb_pin_t   sci_o;
  logic                irq_o;
  int                  bad_count;
  int                  tests_run;

  hsb_sideband dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .cycle_i(cycle_i), .wake_pin_o(wk_o), .smi_request_pin_o(smi_o),
    .sci_request_pin_o(sci_o), .irq_o(irq_o));
  hsb_lpc_host host (.clk_i(clk_i), .cycle_o(cycle_i));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic test_done();
    if (bad_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] exp,
                    input string what);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(what, exp, rdata_o);
  endtask

  // Bounded wait; a stuck level ends the run
  task automatic wait_irq(input logic exp);
    int n;
    n = 0;
    while (irq_o !== exp && n < 8) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk("irq_o", {7'h00, exp}, {7'h00, irq_o});
    if (irq_o !== exp) test_done();
  endtask

  function automatic logic [7:0] pexp(input logic e, input logic l);
    return {5'h00, ~e, e & ~l, 1'b0};
  endfunction

  task automatic pins(input logic [2:0] e, input logic [2:0] l);
    chk("wake pin", pexp(e[2], l[2]), {5'h00, wk_o});
    chk("smi pin", pexp(e[1], l[1]), {5'h00, smi_o});
    chk("sci pin", pexp(e[0], l[0]), {5'h00, sci_o});
  endtask

  task automatic reset_state();
    pins(3'h0, 3'h0);
    rd(hsb_pkg::ADDR_CTRL_ONE, 8'h00, "busy reset");
    rd(hsb_pkg::ADDR_OUT_CTRL, 8'h00, "out ctrl reset");
    wait_irq(1'b0);
  endtask

  // This table, as software, keeps bits 7:3 of both registers clear
  // Every enable and level mix, checked one edge after the write
  task automatic pin_table();
    for (int e = 0; e < 8; e++) begin
      for (int l = 0; l < 8; l++) begin
        wr(hsb_pkg::ADDR_CTRL_ONE, 8'(l));
        wr(hsb_pkg::ADDR_OUT_CTRL, 8'(e));
        pins(3'(e), 3'(l));
      end
    end
  endtask

  task automatic reserved_bits();
    wr(hsb_pkg::ADDR_OUT_CTRL, 8'hFF);
    rd(hsb_pkg::ADDR_OUT_CTRL, 8'h07, "out ctrl bits");
    wr(hsb_pkg::ADDR_CTRL_ONE, 8'hFF);
    rd(hsb_pkg::ADDR_CTRL_ONE, 8'h07, "busy write");
  endtask

  task automatic busy_irq();
    wr(hsb_pkg::ADDR_IRQ_CTRL, 8'h03);
    wr(hsb_pkg::ADDR_IRQ_STATUS, 8'h01);
    wait_irq(1'b0);
    host.pulse(5'h10);
    wait_irq(1'b1);
    rd(hsb_pkg::ADDR_CTRL_ONE, 8'h87, "busy set");
    rd(hsb_pkg::ADDR_IRQ_STATUS, 8'h01, "irq status");
    wr(hsb_pkg::ADDR_IRQ_STATUS, 8'h00);
    wait_irq(1'b0);
    wr(hsb_pkg::ADDR_IRQ_STATUS, 8'h03);
    wait_irq(1'b1);
    wr(hsb_pkg::ADDR_IRQ_CTRL, 8'h01);
    wait_irq(1'b0);
    host.pulse(5'h08);
    wait_irq(1'b1);
    rd(hsb_pkg::ADDR_CTRL_ONE, 8'h07, "busy done");
    rd(hsb_pkg::ADDR_IRQ_STATUS, 8'h02, "irq status fall");
    rd(hsb_pkg::ADDR_IRQ_CTRL, 8'h03, "irq enable");
    wr(hsb_pkg::ADDR_IRQ_CTRL, 8'h03);
    wait_irq(1'b0);
  endtask

  task automatic busy_clears();
    logic [4:0] ends [4] = '{5'h08, 5'h04, 5'h02, 5'h01};
    for (int i = 0; i < 4; i++) begin
      host.pulse(5'h10);
      rd(hsb_pkg::ADDR_CTRL_ONE, 8'h87, "busy set");
      host.pulse(ends[i]);
      rd(hsb_pkg::ADDR_CTRL_ONE, 8'h07, "busy end");
    end
    host.pulse(5'h18);
    rd(hsb_pkg::ADDR_CTRL_ONE, 8'h07, "match with end");
  endtask

  // Busy rise and its status clear in one cycle; the rise must stay
  task automatic set_wins();
    wr(hsb_pkg::ADDR_IRQ_CTRL, 8'h03);
    wait_irq(1'b0);
    fork
      host.pulse(5'h10);
      wr(hsb_pkg::ADDR_IRQ_CTRL, 8'h01);
    join
    wait_irq(1'b1);
    rd(hsb_pkg::ADDR_IRQ_STATUS, 8'h01, "irq set over clear");
    host.pulse(5'h04);
    wr(hsb_pkg::ADDR_IRQ_CTRL, 8'h03);
    wait_irq(1'b0);
  endtask

  task automatic mid_reset();
    wr(hsb_pkg::ADDR_CTRL_ONE, 8'h00);
    host.pulse(5'h10);
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    #1;
    pins(3'h0, 3'h0);
    @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd(hsb_pkg::ADDR_CTRL_ONE, 8'h00, "busy after reset");
    wait_irq(1'b0);
  endtask

  initial begin
    bad_count = 0;
    tests_run = 0;
    rst_b_i   = 1'b0;
    addr_i    = 2'h0;
    wdata_i   = 8'h00;
    wr_i      = 1'b0;
    rd_i      = 1'b0;
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    reset_state();
    pin_table();
    reserved_bits();
    busy_irq();
    busy_clears();
    set_wins();
    mid_reset();
    test_done();
  end
endmodule

/* hsb_lpc_host.sv */
// LPC host model: drives the cycle tracking inputs
`timescale 1ns/1ps
module hsb_lpc_host (
  input  wire logic           clk_i,
  output hsb_pkg::hsb_cycle_t cycle_o
);
  initial begin
    cycle_o = 5'h00;
  end
  // One-cycle bus event; idle after so no stale match lingers
  task automatic pulse(input logic [4:0] ev);
    @(posedge clk_i);
    cycle_o <= ev;
    @(posedge clk_i);
    cycle_o <= 5'h00;
  endtask
endmodule

/* hsb_pkg.sv */
// Package: register map, field positions and shared types for sideband block
package hsb_pkg;

  // Register indices on the plain register port
  localparam logic [1:0] ADDR_OUT_CTRL   = 2'h0; // sideband_output_enable_ctrl
  localparam logic [1:0] ADDR_CTRL_ONE   = 2'h1; // host_iface_ctrl_status_one
  localparam logic [1:0] ADDR_IRQ_STATUS = 2'h2;
  localparam logic [1:0] ADDR_IRQ_CTRL   = 2'h3; // Write clears, read enables

  // sideband_output_enable_ctrl fields
  localparam int WAKE_EN_POS = 2;
  localparam int SMI_EN_POS  = 1;
  localparam int SCI_EN_POS  = 0;

  // host_iface_ctrl_status_one fields
  localparam int BUSY_POS       = 7;
  localparam int WAKE_LEVEL_POS = 2;
  localparam int SMI_LEVEL_POS  = 1;
  localparam int SCI_LEVEL_POS  = 0;

  // Interrupt status fields
  localparam int IRQ_BUSY_SET_POS = 0;
  localparam int IRQ_BUSY_CLR_POS = 1;
  localparam int IRQ_BITS         = 2;

  localparam logic [7:0] OUT_CTRL_RST = 8'h00;
  localparam logic [7:0] CTRL_ONE_RST = 8'h00;
  localparam logic [1:0] IRQ_RST      = 2'h0;

  // One open-drain pin: output value always low, enable pulls
  typedef struct packed {
    logic alt_fn;
    logic oe;
    logic out;
  } hsb_pin_t;

  // LPC cycle tracking inputs
  typedef struct packed {
    logic match;
    logic done;
    logic abort;
    logic lpc_reset;
    logic lpc_shutdown;
  } hsb_cycle_t;

endpackage

/* hsb_sideband.sv */
// Module: open-drain sideband outputs and transfer busy flag
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module hsb_sideband (
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  input  wire logic [1:0]        addr_i,
  input  wire logic [7:0]        wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [7:0]        rdata_o,
  input  wire hsb_pkg::hsb_cycle_t cycle_i,
  output hsb_pkg::hsb_pin_t      wake_pin_o,
  output hsb_pkg::hsb_pin_t      smi_request_pin_o,
  output hsb_pkg::hsb_pin_t      sci_request_pin_o,
  output logic                   irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]                   out_ctrl_reg;
  logic [2:0]                   level_reg;
  logic                         transfer_busy_flag_reg;
  logic [hsb_pkg::IRQ_BITS-1:0] irq_status_reg;
  logic [hsb_pkg::IRQ_BITS-1:0] irq_enable_reg;
  logic [hsb_pkg::IRQ_BITS-1:0] irq_event;
  logic [hsb_pkg::IRQ_BITS-1:0] irq_clear;
  logic                         busy_next;
  logic [7:0]                   rdata_next;
  logic                         wr_out_ctrl;
  logic                         wr_ctrl_one;

  assign wr_out_ctrl = wr_i && (addr_i == hsb_pkg::ADDR_OUT_CTRL);
  assign wr_ctrl_one = wr_i && (addr_i == hsb_pkg::ADDR_CTRL_ONE);

  ////////////////////////////////////////////////////////////////////////////
  // Only the three enable bits are kept; others read zero
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_ctrl_reg <= hsb_pkg::OUT_CTRL_RST;
    end else if (wr_out_ctrl) begin
      out_ctrl_reg <= {5'h00, wdata_i[2:0]};
    end
  end

  // Busy bit of the same register is not writable
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      level_reg <= hsb_pkg::CTRL_ONE_RST[2:0];
    end else if (wr_ctrl_one) begin
      level_reg <= wdata_i[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset and shutdown outrank a new match; end of cycle outranks it too
  always_comb begin
    busy_next = transfer_busy_flag_reg;
    if (cycle_i.match) begin
      busy_next = 1'b1;
    end
    if (cycle_i.done || cycle_i.abort) begin
      busy_next = 1'b0;
    end
    if (cycle_i.lpc_reset || cycle_i.lpc_shutdown) begin
      busy_next = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      transfer_busy_flag_reg <= 1'b0;
    end else begin
      transfer_busy_flag_reg <= busy_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins; one generate over the three channels
  logic [2:0] pin_en;
  logic [2:0] pin_lvl;
  hsb_pkg::hsb_pin_t pin_reg [3];

  assign pin_en = {out_ctrl_reg[hsb_pkg::WAKE_EN_POS],
                   out_ctrl_reg[hsb_pkg::SMI_EN_POS],
                   out_ctrl_reg[hsb_pkg::SCI_EN_POS]};
  assign pin_lvl = {level_reg[hsb_pkg::WAKE_LEVEL_POS],
                    level_reg[hsb_pkg::SMI_LEVEL_POS],
                    level_reg[hsb_pkg::SCI_LEVEL_POS]};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_pin
      hsb_pkg::hsb_pin_t pin_next;
      logic              en_n;
      logic              lvl_n;
      assign en_n  = (wr_out_ctrl) ? wdata_i[g] : pin_en[g];
      assign lvl_n = (wr_ctrl_one) ? wdata_i[g] : pin_lvl[g];
      always_comb begin
        pin_next.alt_fn = !en_n;
        pin_next.oe     = en_n && !lvl_n;
        pin_next.out    = 1'b0;
      end
      always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          pin_reg[g] <= '{alt_fn: 1'b1, oe: 1'b0, out: 1'b0};
        end else begin
          pin_reg[g] <= pin_next;
        end
      end
    end
  endgenerate

  // Channel 2 is wake, 1 is SMI, 0 is SCI
  assign wake_pin_o        = pin_reg[2];
  assign smi_request_pin_o = pin_reg[1];
  assign sci_request_pin_o = pin_reg[0];

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: busy rise and fall; set wins over clear
  assign irq_event = {transfer_busy_flag_reg && !busy_next,
                      !transfer_busy_flag_reg && busy_next};
  assign irq_clear = (wr_i && addr_i == hsb_pkg::ADDR_IRQ_CTRL) ?
                     wdata_i[hsb_pkg::IRQ_BITS-1:0] : '0;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_status_reg <= hsb_pkg::IRQ_RST;
    end else begin
      irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_event;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_enable_reg <= hsb_pkg::IRQ_RST;
    end else if (wr_i && addr_i == hsb_pkg::ADDR_IRQ_STATUS) begin
      irq_enable_reg <= wdata_i[hsb_pkg::IRQ_BITS-1:0];
    end
  end

  // Registered from the next status value, so the line changes on the same edge as status
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(((irq_status_reg & ~irq_clear) | irq_event) &
                 irq_enable_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port, data one cycle after strobe, zero otherwise
  always_comb begin
    rdata_next = 8'h00;
    if (rd_i) begin
      unique case (addr_i)
        hsb_pkg::ADDR_OUT_CTRL: rdata_next = out_ctrl_reg;
        hsb_pkg::ADDR_CTRL_ONE: begin
          rdata_next = {transfer_busy_flag_reg, 4'h0, level_reg};
        end
        hsb_pkg::ADDR_IRQ_STATUS: rdata_next = {6'h00, irq_status_reg};
        hsb_pkg::ADDR_IRQ_CTRL:   rdata_next = {6'h00, irq_enable_reg};
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence wr_wake_low_s;
    wr_out_ctrl && wdata_i[hsb_pkg::WAKE_EN_POS] && !wr_ctrl_one &&
      !level_reg[hsb_pkg::WAKE_LEVEL_POS];
  endsequence

  wake_pull_low_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    wr_wake_low_s |=> (wake_pin_o.oe && !wake_pin_o.alt_fn))
    else $error("wake pin not pulled low after enable");

  alt_release_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (wr_out_ctrl && !wdata_i[0]) |=> (sci_request_pin_o.alt_fn &&
                                      !sci_request_pin_o.oe))
    else $error("sci pin not released to alternate function");

  smi_float_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (wr_ctrl_one && wdata_i[1]) |=> !smi_request_pin_o.oe)
    else $error("smi pin driven while level is high");

  never_high_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    !wake_pin_o.out && !smi_request_pin_o.out && !sci_request_pin_o.out)
    else $error("sideband pin driven high");

  busy_set_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (cycle_i.match && !cycle_i.done && !cycle_i.abort &&
     !cycle_i.lpc_reset && !cycle_i.lpc_shutdown) |=> transfer_busy_flag_reg)
    else $error("busy not set on matching cycle");

  busy_reset_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (cycle_i.lpc_reset || cycle_i.lpc_shutdown) |=> !transfer_busy_flag_reg)
    else $error("busy not cleared on lpc reset");

  busy_end_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (cycle_i.done || cycle_i.abort) |=> !transfer_busy_flag_reg)
    else $error("busy not cleared at cycle end");

  busy_read_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (rd_i && addr_i == hsb_pkg::ADDR_CTRL_ONE) |=>
      (rdata_o[hsb_pkg::BUSY_POS] == $past(transfer_busy_flag_reg)))
    else $error("busy flag read back wrong");

  busy_hold_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (!transfer_busy_flag_reg && !cycle_i.match) |=> !transfer_busy_flag_reg)
    else $error("busy set without a match");

  pin_lag_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    wr_out_ctrl |=> (wake_pin_o.alt_fn ==
                     !$past(wdata_i[hsb_pkg::WAKE_EN_POS])))
    else $error("wake pin not updated one edge after write");

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel checks; a write decides the pin one edge later
  sequence wr_wake_off_s;
    wr_out_ctrl && !wdata_i[hsb_pkg::WAKE_EN_POS];
  endsequence

  sequence wr_smi_low_s;
    wr_out_ctrl && wdata_i[hsb_pkg::SMI_EN_POS] &&
      !level_reg[hsb_pkg::SMI_LEVEL_POS];
  endsequence

  sequence wr_sci_low_s;
    wr_out_ctrl && wdata_i[hsb_pkg::SCI_EN_POS] &&
      !level_reg[hsb_pkg::SCI_LEVEL_POS];
  endsequence

  // Rise and clear in one cycle; losing the rise would hide an event
  sequence busy_rise_clear_s;
    irq_event[hsb_pkg::IRQ_BUSY_SET_POS] &&
      irq_clear[hsb_pkg::IRQ_BUSY_SET_POS];
  endsequence

  wake_release_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    wr_wake_off_s |=> (wake_pin_o.alt_fn && !wake_pin_o.oe))
    else $error("wake pin not released to alternate function");

  wake_float_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (wr_ctrl_one && wdata_i[hsb_pkg::WAKE_LEVEL_POS]) |=> !wake_pin_o.oe)
    else $error("wake pin driven while level is high");

  smi_release_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (wr_out_ctrl && !wdata_i[hsb_pkg::SMI_EN_POS]) |=>
      (smi_request_pin_o.alt_fn && !smi_request_pin_o.oe))
    else $error("smi pin not released to alternate function");

  smi_pull_low_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    wr_smi_low_s |=> (smi_request_pin_o.oe && !smi_request_pin_o.alt_fn))
    else $error("smi pin not pulled low after enable");

  sci_pull_low_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    wr_sci_low_s |=> (sci_request_pin_o.oe && !sci_request_pin_o.alt_fn))
    else $error("sci pin not pulled low after enable");

  sci_float_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (wr_ctrl_one && wdata_i[hsb_pkg::SCI_LEVEL_POS]) |=>
      !sci_request_pin_o.oe)
    else $error("sci pin driven while level is high");

  // A pin handed away must not also be pulled by this block
  pin_exclusive_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    !(wake_pin_o.oe && wake_pin_o.alt_fn) &&
    !(smi_request_pin_o.oe && smi_request_pin_o.alt_fn) &&
    !(sci_request_pin_o.oe && sci_request_pin_o.alt_fn))
    else $error("sideband pin pulled while handed away");

  busy_no_write_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (wr_ctrl_one && wdata_i[hsb_pkg::BUSY_POS] &&
     !transfer_busy_flag_reg && !cycle_i.match) |=> !transfer_busy_flag_reg)
    else $error("busy flag changed by a register write");

  level_track_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    wr_ctrl_one |=> (level_reg == $past(wdata_i[2:0])))
    else $error("level bits not taken from write");

  irq_set_wins_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    busy_rise_clear_s |=> irq_status_reg[hsb_pkg::IRQ_BUSY_SET_POS])
    else $error("busy rise lost to a status clear");

  irq_fall_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (transfer_busy_flag_reg && (cycle_i.done || cycle_i.abort)) |=>
      irq_status_reg[hsb_pkg::IRQ_BUSY_CLR_POS])
    else $error("busy fall not recorded");

  // Idle read port shows zero, so stale data cannot be mistaken
  rdata_idle_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    !rd_i |=> (rdata_o == 8'h00))
    else $error("read data standing without a read");

endmodule
